//--- slms_pkg.sv
/*
 * shared types and constants for the serial link master sequencer:
 * control character codes, receive event and transmit request carriers,
 * retry limits and reply timer lengths.
 * assumes a 100 MHz system clock; timer times are not fixed by the link.
 */
package slms_pkg;

	// clock
	localparam int CLK_PERIOD_NS = 10;

	// control characters on the line
	localparam logic [7:0] CHR_SOH = 8'h01;
	localparam logic [7:0] CHR_STX = 8'h02;
	localparam logic [7:0] CHR_EOT = 8'h04;
	localparam logic [7:0] CHR_ENQ = 8'h05;
	localparam logic [7:0] CHR_ACK = 8'h06;
	localparam logic [7:0] CHR_NAK = 8'h15;
	localparam logic [7:0] CHR_NONE = 8'h00;

	// retry limits
	localparam logic [5:0] ENQ_RETRY_MAX   = 6'h20;
	localparam logic [5:0] OTHER_RETRY_MAX = 6'h03;

	// reply timer times and derived cycle counts
	localparam int TMR_W                 = 12;
	localparam int ENQ_REPLY_TIME_NS     = 20000;
	localparam int HDR_REPLY_TIME_NS     = 30000;
	localparam int BLK_REPLY_TIME_NS     = 30000;
	localparam int TEXT_START_TIME_NS    = 30000;
	localparam int DATA_RECEIVE_TIME_NS  = 40000;
	localparam int END_WAIT_TIME_NS      = 20000;
	localparam logic [TMR_W-1:0] ENQ_REPLY_CYC    = TMR_W'(ENQ_REPLY_TIME_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] HDR_REPLY_CYC    = TMR_W'(HDR_REPLY_TIME_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] BLK_REPLY_CYC    = TMR_W'(BLK_REPLY_TIME_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] TEXT_START_CYC   = TMR_W'(TEXT_START_TIME_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] DATA_RECEIVE_CYC = TMR_W'(DATA_RECEIVE_TIME_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] END_WAIT_CYC     = TMR_W'(END_WAIT_TIME_NS / CLK_PERIOD_NS);

	// received events
	typedef enum logic [3:0] {
		EV_ENQ, EV_ACK, EV_NAK, EV_EOT, EV_SOH, EV_STX,
		EV_CHAR, EV_GOOD_DATA, EV_BAD_DATA
	} slms_ev_t;

	typedef struct packed {
		logic     valid;
		slms_ev_t kind;
	} slms_rx_t;

	// transmit requests
	typedef enum logic [2:0] {
		TX_ENQ, TX_QENQ, TX_HDR, TX_DATA, TX_ACK, TX_NAK, TX_EOT
	} slms_tx_kind_t;

	typedef struct packed {
		logic          valid;
		slms_tx_kind_t kind;
		logic [7:0]    code;
	} slms_tx_t;

	typedef enum logic [2:0] {
		TM_ENQ, TM_HDR, TM_BLK, TM_TEXT, TM_DATA, TM_END
	} slms_tmr_sel_t;

endpackage : slms_pkg

//--- slms_timer.sv
/*
 * one-shot reply timer: loads a cycle count on start, halts on stop without clearing the count,
 * and gives a one-cycle expiry pulse when the count runs out.
 * assumes start and stop are never asked in the same cycle as meaningful.
 */
`timescale 1ns/1ns
`default_nettype none

module slms_timer #(
	parameter int W = 12
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// control
	input  wire logic         start_i,
	input  wire logic [W-1:0] len_i,
	input  wire logic         stop_i,
	// status
	output logic              expired_o
);

	logic [W-1:0] cnt;
	logic         run;
	logic [W-1:0] next_cnt;
	logic         next_run;
	logic         next_expired;

	always_comb begin
		next_cnt     = cnt;
		next_run     = run;
		next_expired = 1'b0;
		if (start_i) begin
			next_cnt = len_i;
			next_run = 1'b1;
		end else if (stop_i) begin
			next_run = 1'b0;
		end else if (run) begin
			if (cnt <= W'(1)) begin
				next_run     = 1'b0;
				next_expired = 1'b1;
			end else begin
				next_cnt = cnt - W'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt       <= '0;
			run       <= 1'b0;
			expired_o <= 1'b0;
		end else begin
			cnt       <= next_cnt;
			run       <= next_run;
			expired_o <= next_expired;
		end
	end

endmodule : slms_timer
`default_nettype wire

//--- slms_master.sv
/*
 * link-layer master sequencer: opens a session, sends the header, moves
 * data blocks either way with acknowledge handshakes and retries, closes.
 * assumes a receiver that reports one classified event per cycle and a
 * transmitter that accepts one transmit request per cycle without stalling.
 */
`timescale 1ns/1ns
`default_nettype none

module slms_master (
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              arst_n_i,
	// controller side
	input  wire logic              communication_request_i,
	input  wire logic              quick_enquiry_sequence_i,
	input  wire logic              read_dir_i,
	input  wire logic              data_ready_i,
	input  wire logic              last_block_i,
	output logic                   fetch_data_o,
	output logic                   deliver_data_o,
	output logic                   busy_o,
	// link side
	input  wire slms_pkg::slms_rx_t rx_i,
	output slms_pkg::slms_tx_t      tx_o
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_ENQ_REPLY, ST_HDR_REPLY, ST_BLK_REPLY,
		ST_TEXT_WAIT, ST_DATA_WAIT, ST_END_WAIT, ST_QUICK_WAIT
	} slms_state_t;

	logic rst_sync0;
	logic rst_n;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync0 <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_sync0 <= 1'b1;
			rst_n     <= rst_sync0;
		end
	end

	function automatic slms_pkg::slms_tx_t tx_pkt(slms_pkg::slms_tx_kind_t k);
		slms_pkg::slms_tx_t t;
		t.valid = 1'b1;
		t.kind  = k;
		unique case (k)
			slms_pkg::TX_ENQ,
			slms_pkg::TX_QENQ: t.code = slms_pkg::CHR_ENQ;
			slms_pkg::TX_ACK:  t.code = slms_pkg::CHR_ACK;
			slms_pkg::TX_NAK:  t.code = slms_pkg::CHR_NAK;
			slms_pkg::TX_EOT:  t.code = slms_pkg::CHR_EOT;
			slms_pkg::TX_HDR:  t.code = slms_pkg::CHR_SOH;
			slms_pkg::TX_DATA: t.code = slms_pkg::CHR_STX;
			default:           t.code = slms_pkg::CHR_NONE;
		endcase
		return t;
	endfunction : tx_pkt

	function automatic logic [slms_pkg::TMR_W-1:0] tmr_len(slms_pkg::slms_tmr_sel_t s);
		unique case (s)
			slms_pkg::TM_ENQ:  return slms_pkg::ENQ_REPLY_CYC;
			slms_pkg::TM_HDR:  return slms_pkg::HDR_REPLY_CYC;
			slms_pkg::TM_BLK:  return slms_pkg::BLK_REPLY_CYC;
			slms_pkg::TM_TEXT: return slms_pkg::TEXT_START_CYC;
			slms_pkg::TM_DATA: return slms_pkg::DATA_RECEIVE_CYC;
			default:           return slms_pkg::END_WAIT_CYC;
		endcase
	endfunction : tmr_len

	slms_state_t        state, next_state;
	logic [5:0]         enquiry_retry_count, next_enquiry_retry_count;
	logic [5:0]         header_retry_count, next_header_retry_count;
	logic [5:0]         block_retry_count, next_block_retry_count;
	logic [5:0]         quick_retry_count, next_quick_retry_count;
	logic               read_dir, next_read_dir;
	logic               await_data, next_await_data;
	slms_pkg::slms_tx_t next_tx;
	logic               next_fetch, next_deliver;
	logic               tmr_start, tmr_stop, timeout;
	slms_pkg::slms_tmr_sel_t tmr_sel;
	logic               ev;
	slms_pkg::slms_ev_t kind;

	assign ev   = rx_i.valid;
	assign kind = rx_i.kind;

	slms_timer #(.W(slms_pkg::TMR_W)) u_timer (
		.clk_i    (sys_clk_i),
		.rst_n_i  (rst_n),
		.start_i  (tmr_start),
		.len_i    (tmr_len(tmr_sel)),
		.stop_i   (tmr_stop),
		.expired_o(timeout)
	);

	always_comb begin
		next_state               = state;
		next_enquiry_retry_count = enquiry_retry_count;
		next_header_retry_count  = header_retry_count;
		next_block_retry_count   = block_retry_count;
		next_quick_retry_count   = quick_retry_count;
		next_read_dir            = read_dir;
		next_await_data          = await_data;
		next_tx                  = '0;
		next_fetch               = 1'b0;
		next_deliver             = 1'b0;
		tmr_start                = 1'b0;
		tmr_sel                  = slms_pkg::TM_ENQ;
		tmr_stop                 = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (communication_request_i) begin
					next_enquiry_retry_count = '0;
					next_header_retry_count  = '0;
					next_block_retry_count   = '0;
					next_quick_retry_count   = '0;
					next_read_dir            = read_dir_i;
					tmr_start                = 1'b1;
					if (quick_enquiry_sequence_i) begin
						next_tx    = tx_pkt(slms_pkg::TX_QENQ);
						next_state = ST_QUICK_WAIT;
					end else begin
						next_tx    = tx_pkt(slms_pkg::TX_ENQ);
						next_state = ST_ENQ_REPLY;
					end
				end
			end
			ST_ENQ_REPLY: begin
				if (ev && kind == slms_pkg::EV_ACK) begin
					next_tx    = tx_pkt(slms_pkg::TX_HDR);
					tmr_start  = 1'b1;
					tmr_sel    = slms_pkg::TM_HDR;
					next_state = ST_HDR_REPLY;
				end else if ((ev && kind == slms_pkg::EV_NAK) || (!ev && timeout)) begin
					if (enquiry_retry_count <= slms_pkg::ENQ_RETRY_MAX) begin
						next_enquiry_retry_count = enquiry_retry_count + 6'h01;
						next_tx   = tx_pkt(slms_pkg::TX_ENQ);
						tmr_start = 1'b1;
					end else begin
						next_tx    = tx_pkt(slms_pkg::TX_EOT);
						next_state = ST_IDLE;
					end
				end else if (ev) begin
					next_tx    = tx_pkt(slms_pkg::TX_EOT);
					next_state = ST_IDLE;
				end
			end
			ST_HDR_REPLY: begin
				if (ev && kind == slms_pkg::EV_ACK) begin
					if (read_dir) begin
						next_state = ST_TEXT_WAIT;
						tmr_start  = 1'b1;
						tmr_sel    = slms_pkg::TM_TEXT;
					end else begin
						next_fetch = 1'b1;
						next_tx    = tx_pkt(slms_pkg::TX_DATA);
						tmr_start  = 1'b1;
						tmr_sel    = slms_pkg::TM_BLK;
						next_state = ST_BLK_REPLY;
					end
				end else if (ev && kind == slms_pkg::EV_NAK
					&& header_retry_count <= slms_pkg::OTHER_RETRY_MAX) begin
					next_header_retry_count = header_retry_count + 6'h01;
					next_tx   = tx_pkt(slms_pkg::TX_HDR);
					tmr_start = 1'b1;
					tmr_sel   = slms_pkg::TM_HDR;
				end else if (ev || timeout) begin
					next_tx    = tx_pkt(slms_pkg::TX_EOT);
					next_state = ST_IDLE;
				end
			end
			ST_BLK_REPLY: begin
				if (await_data) begin
					if (ev) begin
						next_tx    = tx_pkt(slms_pkg::TX_EOT);
						next_state = ST_IDLE;
					end else if (data_ready_i) begin
						next_block_retry_count = '0;
						next_tx         = tx_pkt(slms_pkg::TX_DATA);
						next_await_data = 1'b0;
						tmr_start       = 1'b1;
						tmr_sel         = slms_pkg::TM_BLK;
					end
				end else if (ev && kind == slms_pkg::EV_ACK) begin
					if (last_block_i) begin
						next_tx    = tx_pkt(slms_pkg::TX_EOT);
						next_state = ST_IDLE;
					end else begin
						next_await_data = 1'b1;
						tmr_stop        = 1'b1;
					end
				end else if (ev && kind == slms_pkg::EV_NAK
					&& block_retry_count <= slms_pkg::OTHER_RETRY_MAX) begin
					next_block_retry_count = block_retry_count + 6'h01;
					next_tx   = tx_pkt(slms_pkg::TX_DATA);
					tmr_start = 1'b1;
					tmr_sel   = slms_pkg::TM_BLK;
				end else if (ev || timeout) begin
					next_tx    = tx_pkt(slms_pkg::TX_EOT);
					next_state = ST_IDLE;
				end
			end
			ST_TEXT_WAIT: begin
				if (ev && kind == slms_pkg::EV_STX) begin
					tmr_start  = 1'b1;
					tmr_sel    = slms_pkg::TM_DATA;
					next_state = ST_DATA_WAIT;
				end else if (ev || timeout) begin
					next_tx    = tx_pkt(slms_pkg::TX_EOT);
					next_state = ST_IDLE;
				end
			end
			ST_DATA_WAIT: begin
				if (ev && kind == slms_pkg::EV_GOOD_DATA) begin
					next_deliver = 1'b1;
					next_tx      = tx_pkt(slms_pkg::TX_ACK);
					tmr_start    = 1'b1;
					if (last_block_i) begin
						tmr_sel    = slms_pkg::TM_END;
						next_state = ST_END_WAIT;
					end else begin
						tmr_sel    = slms_pkg::TM_TEXT;
						next_state = ST_TEXT_WAIT;
					end
				end else if (ev && kind == slms_pkg::EV_BAD_DATA
					&& block_retry_count <= slms_pkg::OTHER_RETRY_MAX) begin
					next_block_retry_count = block_retry_count + 6'h01;
					next_tx    = tx_pkt(slms_pkg::TX_NAK);
					tmr_start  = 1'b1;
					tmr_sel    = slms_pkg::TM_TEXT;
					next_state = ST_TEXT_WAIT;
				end else if (ev || timeout) begin
					next_tx    = tx_pkt(slms_pkg::TX_EOT);
					next_state = ST_IDLE;
				end
			end
			ST_END_WAIT: begin
				if (ev || timeout) begin
					next_tx    = tx_pkt(slms_pkg::TX_EOT);
					next_state = ST_IDLE;
				end
			end
			ST_QUICK_WAIT: begin
				if (ev && kind == slms_pkg::EV_GOOD_DATA) begin
					next_state = ST_IDLE;
					tmr_stop   = 1'b1;
				end else if ((ev && kind == slms_pkg::EV_BAD_DATA) || (!ev && timeout)) begin
					if (quick_retry_count <= slms_pkg::OTHER_RETRY_MAX) begin
						next_quick_retry_count = quick_retry_count + 6'h01;
						next_tx   = tx_pkt(slms_pkg::TX_QENQ);
						tmr_start = 1'b1;
					end else begin
						next_state = ST_IDLE;
						tmr_stop   = 1'b1;
					end
				end else if (ev) begin
					next_tx    = tx_pkt(slms_pkg::TX_EOT);
					next_state = ST_IDLE;
				end
			end
		endcase
		if (next_state == ST_IDLE) begin
			next_await_data = 1'b0;
			if (state != ST_IDLE) begin
				tmr_stop = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state               <= ST_IDLE;
			enquiry_retry_count <= '0;
			header_retry_count  <= '0;
			block_retry_count   <= '0;
			quick_retry_count   <= '0;
			read_dir            <= 1'b0;
			await_data          <= 1'b0;
			tx_o                <= '0;
			fetch_data_o        <= 1'b0;
			deliver_data_o      <= 1'b0;
		end else begin
			state               <= next_state;
			enquiry_retry_count <= next_enquiry_retry_count;
			header_retry_count  <= next_header_retry_count;
			block_retry_count   <= next_block_retry_count;
			quick_retry_count   <= next_quick_retry_count;
			read_dir            <= next_read_dir;
			await_data          <= next_await_data;
			tx_o                <= next_tx;
			fetch_data_o        <= next_fetch;
			deliver_data_o      <= next_deliver;
		end
	end

	assign busy_o = (state != ST_IDLE);

	property p_req_normal;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_IDLE && communication_request_i && !quick_enquiry_sequence_i)
		|=> (state == ST_ENQ_REPLY && tx_o.valid && tx_o.kind == slms_pkg::TX_ENQ
			&& enquiry_retry_count == 6'h00);
	endproperty
	a_req_normal: assert property (p_req_normal) else $error("enquiry not sent on request");

	property p_req_quick;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_IDLE && communication_request_i && quick_enquiry_sequence_i)
		|=> (state == ST_QUICK_WAIT && tx_o.kind == slms_pkg::TX_QENQ && tx_o.code == 8'h05);
	endproperty
	a_req_quick: assert property (p_req_quick) else $error("quick enquiry not sent");

	property p_enq_ack;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_ENQ_REPLY && ev && kind == slms_pkg::EV_ACK)
		|=> (state == ST_HDR_REPLY && tx_o.kind == slms_pkg::TX_HDR);
	endproperty
	a_enq_ack: assert property (p_enq_ack) else $error("header not sent after enquiry ack");

	property p_enq_retry;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_ENQ_REPLY && ev && kind == slms_pkg::EV_NAK && enquiry_retry_count <= 6'h20)
		|=> (state == ST_ENQ_REPLY && enquiry_retry_count == $past(enquiry_retry_count) + 6'h01
			&& tx_o.kind == slms_pkg::TX_ENQ);
	endproperty
	a_enq_retry: assert property (p_enq_retry) else $error("enquiry retry wrong");

	property p_hdr_give_up;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_HDR_REPLY && ev && kind == slms_pkg::EV_NAK && header_retry_count > 6'h03)
		|=> (state == ST_IDLE && tx_o.valid && tx_o.code == 8'h04);
	endproperty
	a_hdr_give_up: assert property (p_hdr_give_up) else $error("header retries not ended");

	property p_blk_last;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_BLK_REPLY && !await_data && ev && kind == slms_pkg::EV_ACK && last_block_i)
		|=> (state == ST_IDLE && tx_o.kind == slms_pkg::TX_EOT) ##1 !busy_o;
	endproperty
	a_blk_last: assert property (p_blk_last) else $error("last block ack did not end");

	property p_text_start;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_TEXT_WAIT && ev && kind == slms_pkg::EV_STX)
		|=> (state == ST_DATA_WAIT && !tx_o.valid);
	endproperty
	a_text_start: assert property (p_text_start) else $error("text start not taken");

	property p_good_block;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_DATA_WAIT && ev && kind == slms_pkg::EV_GOOD_DATA)
		|=> (deliver_data_o && tx_o.code == 8'h06
			&& state == ($past(last_block_i) ? ST_END_WAIT : ST_TEXT_WAIT));
	endproperty
	a_good_block: assert property (p_good_block) else $error("good block not acked");

	property p_quick_give_up;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_QUICK_WAIT && ev && kind == slms_pkg::EV_BAD_DATA && quick_retry_count > 6'h03)
		|=> (state == ST_IDLE && !tx_o.valid);
	endproperty
	a_quick_give_up: assert property (p_quick_give_up) else $error("quick end sent a char");

	property p_stray_eot;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state == ST_ENQ_REPLY && ev && kind == slms_pkg::EV_EOT)
		|=> (state == ST_IDLE && tx_o.kind == slms_pkg::TX_EOT);
	endproperty
	a_stray_eot: assert property (p_stray_eot) else $error("stray end not answered");

endmodule : slms_master
`default_nettype wire

//--- slms_slave_model.sv
/* slave station model facing the master sequencer on the link.
   assumes one-cycle transmit requests; replies at most one event per cycle, with 1 to 3 idle cycles before each. */
`timescale 1ns/1ns
`default_nettype none

module slms_slave_model (
	// clock and session start
	input  wire logic                    sys_clk_i,
	input  wire logic                    start_i,
	// behaviour: direction, block count, faulted kind, fault count, fault event
	input  wire logic                    rd_i,
	input  wire logic [7:0]              nblk_i,
	input  wire slms_pkg::slms_tx_kind_t fkind_i,
	input  wire logic [7:0]              fn_i,
	input  wire slms_pkg::slms_ev_t      fev_i,
	// link
	input  wire slms_pkg::slms_tx_t      tx_i,
	output var  slms_pkg::slms_rx_t      rx_o
);
	int                 used = 0;
	int                 good = 0;
	int                 wait_c = 0;
	slms_pkg::slms_ev_t e;
	slms_pkg::slms_ev_t q[$];

	initial rx_o = '0;

	// the first fn_i replies to fkind_i become fev_i
	function automatic slms_pkg::slms_ev_t pick(input slms_pkg::slms_tx_kind_t k,
		input slms_pkg::slms_ev_t ok);
		if (k != fkind_i || used >= int'(fn_i))
			return ok;
		used++;
		return fev_i;
	endfunction : pick

	// an enquiry event stands for silence, so the master times out
	task automatic put(input slms_pkg::slms_ev_t v);
		if (q.size() == 0)
			wait_c = 1 + $urandom % 3;
		if (v != slms_pkg::EV_ENQ)
			q.push_back(v);
	endtask : put

	task automatic send_block();
		put(slms_pkg::EV_STX);
		e = pick(slms_pkg::TX_ACK, slms_pkg::EV_GOOD_DATA);
		put(e);
		good += int'(e == slms_pkg::EV_GOOD_DATA);
	endtask : send_block

	always @(posedge sys_clk_i) begin
		if (start_i === 1'b1) begin
			used = 0;
			good = 0;
			q.delete();
		end
		#2;
		rx_o = '0;
		if (tx_i.valid === 1'b1) begin
			case (tx_i.kind)
				slms_pkg::TX_HDR: begin
					e = pick(tx_i.kind, slms_pkg::EV_ACK);
					put(e);
					if (rd_i && e == slms_pkg::EV_ACK)
						send_block();
				end
				slms_pkg::TX_QENQ: put(pick(tx_i.kind, slms_pkg::EV_GOOD_DATA));
				slms_pkg::TX_NAK: send_block();
				slms_pkg::TX_ACK: begin
					if (good < int'(nblk_i))
						send_block();
					else
						put(slms_pkg::EV_EOT);
				end
				slms_pkg::TX_EOT: ;
				default: put(pick(tx_i.kind, slms_pkg::EV_ACK));
			endcase
		end
		if (q.size() > 0) begin
			if (wait_c == 0) begin
				rx_o = '{1'b1, q.pop_front()};
				wait_c = 1 + $urandom % 3;
			end else
				wait_c--;
		end
	end
endmodule : slms_slave_model

`default_nettype wire

//--- test_serial_link_master_sequencer.sv
/* self-checking bench: master sequencer against a slave station model.
   assumes package timer lengths; each session checks the transmit order. */
`timescale 1ns/1ns
`default_nettype none

module test_serial_link_master_sequencer;
	logic                    sys_clk_i = 1'b0;
	logic                    arst_n_i = 1'b0;
	logic                    req = 1'b0;
	logic                    quick = 1'b0;
	logic                    rd = 1'b0;
	logic                    ready = 1'b0;
	logic                    last_blk;
	logic                    fetch;
	logic                    deliver;
	logic                    busy;
	slms_pkg::slms_rx_t      rx;
	slms_pkg::slms_tx_t      tx;
	slms_pkg::slms_tx_kind_t fkind = slms_pkg::TX_ENQ;
	slms_pkg::slms_tx_kind_t lastk = slms_pkg::TX_EOT;
	slms_pkg::slms_tx_kind_t exp_q[$];
	slms_pkg::slms_ev_t      fev = slms_pkg::EV_NAK;
	logic [7:0]              fn = 8'h00;
	int                      errors = 0;
	int                      n_compared = 0;
	int                      nblk = 1;
	int                      done = 0;
	int                      fetches = 0;
	int                      delivers = 0;
	int                      rdy_cd = 0;
	slms_pkg::slms_tx_kind_t order[7] = '{slms_pkg::TX_QENQ, slms_pkg::TX_ENQ, slms_pkg::TX_HDR,
		slms_pkg::TX_DATA, slms_pkg::TX_NAK, slms_pkg::TX_ACK, slms_pkg::TX_EOT};
	slms_pkg::slms_tx_kind_t ks[3] = '{slms_pkg::TX_ENQ, slms_pkg::TX_HDR, slms_pkg::TX_DATA};
	slms_pkg::slms_ev_t      evs[5] = '{slms_pkg::EV_EOT, slms_pkg::EV_SOH, slms_pkg::EV_STX,
		slms_pkg::EV_CHAR, slms_pkg::EV_BAD_DATA};

	assign last_blk = (done >= nblk - 1);

	always #(slms_pkg::CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;

	slms_master DUT (
		.sys_clk_i               (sys_clk_i),
		.arst_n_i                (arst_n_i),
		.communication_request_i (req),
		.quick_enquiry_sequence_i(quick),
		.read_dir_i              (rd),
		.data_ready_i            (ready),
		.last_block_i            (last_blk),
		.fetch_data_o            (fetch),
		.deliver_data_o          (deliver),
		.busy_o                  (busy),
		.rx_i                    (rx),
		.tx_o                    (tx)
	);

	slms_slave_model u_slave (
		.sys_clk_i(sys_clk_i),
		.start_i  (req),
		.rd_i     (rd),
		.nblk_i   (8'(nblk)),
		.fkind_i  (fkind),
		.fn_i     (fn),
		.fev_i    (fev),
		.tx_i     (tx),
		.rx_o     (rx)
	);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// standard single-byte control codes
	function automatic logic [7:0] code_of(input slms_pkg::slms_tx_kind_t k);
		case (k)
			slms_pkg::TX_ENQ, slms_pkg::TX_QENQ: return 8'h05;
			slms_pkg::TX_HDR: return 8'h01;
			slms_pkg::TX_DATA: return 8'h02;
			slms_pkg::TX_ACK: return 8'h06;
			slms_pkg::TX_NAK: return 8'h15;
			default: return 8'h04;
		endcase
	endfunction : code_of

	// monitor: reads values from before the edge
	always @(posedge sys_clk_i) begin
		if (tx.valid === 1'b1) begin
			lastk <= tx.kind;
			if (exp_q.size() == 0) begin
				check("tx_extra", 32'(tx.kind), 32'hFF);
			end else begin
				check("tx_kind", 32'(tx.kind), 32'(exp_q[0]));
				check("tx_code", 32'(tx.code), 32'(code_of(exp_q[0])));
				void'(exp_q.pop_front());
			end
		end
		if (rx.valid === 1'b1 && rx.kind == slms_pkg::EV_ACK && lastk == slms_pkg::TX_DATA) begin
			done <= #2 done + 1;
			if (last_blk !== 1'b1)
				rdy_cd <= 3 + int'($urandom % 3);
		end else if (rdy_cd > 0)
			rdy_cd <= rdy_cd - 1;
		ready <= #2 (rdy_cd == 1);
		if (deliver === 1'b1) begin
			done <= #2 done + 1;
			delivers <= delivers + 1;
		end
		if (fetch === 1'b1)
			fetches <= fetches + 1;
	end

	task automatic run(input slms_pkg::slms_tx_kind_t k, input int c, input slms_pkg::slms_ev_t e,
		input logic q, r, input int nb, fet, del, input int n[7]);
		int i;
		fkind = k;
		fn = 8'(c);
		fev = e;
		nblk = nb;
		done = 0;
		fetches = 0;
		delivers = 0;
		exp_q.delete();
		for (i = 0; i < 7; i++)
			repeat (n[i]) exp_q.push_back(order[i]);
		@(posedge sys_clk_i);
		#2;
		req = 1'b1;
		quick = q;
		rd = r;
		@(posedge sys_clk_i);
		#2;
		req = 1'b0;
		check("busy", 32'(busy), 32'h1);
		i = 0;
		while (busy === 1'b1 && i < 20000) begin
			@(posedge sys_clk_i);
			#2;
			i++;
		end
		if (i >= 20000) begin
			errors++;
			results();
		end
		repeat (4) @(posedge sys_clk_i);
		#2;
		check("missing_tx", 32'(exp_q.size()), 32'h0);
		check("fetch", 32'(fetches), 32'(fet));
		if (del >= 0)
			check("deliver", 32'(delivers), 32'(del));
		$display("test done: fault kind %0d count %0d quick %0b read %0b", k, c, q, r);
	endtask : run

	initial begin
		void'($urandom(32'h49f7702d));
		repeat (16) @(posedge sys_clk_i);
		#2;
		arst_n_i = 1'b1;
		repeat (3) @(posedge sys_clk_i);
		run(slms_pkg::TX_ENQ, 0, slms_pkg::EV_NAK, 0, 0, 1, 1, 0, '{0,1,1,1,0,0,1});
		run(slms_pkg::TX_DATA, 2, slms_pkg::EV_NAK, 0, 0, 3, 1, 0, '{0,1,1,5,0,0,1});
		run(slms_pkg::TX_HDR, 4, slms_pkg::EV_NAK, 0, 0, 1, 1, 0, '{0,1,5,1,0,0,1});
		run(slms_pkg::TX_HDR, 5, slms_pkg::EV_NAK, 0, 0, 1, 0, 0, '{0,1,5,0,0,0,1});
		run(slms_pkg::TX_ENQ, 33, slms_pkg::EV_NAK, 0, 0, 1, 1, 0, '{0,34,1,1,0,0,1});
		run(slms_pkg::TX_ENQ, 34, slms_pkg::EV_NAK, 0, 0, 1, 0, 0, '{0,34,0,0,0,0,1});
		run(slms_pkg::TX_DATA, 5, slms_pkg::EV_NAK, 0, 0, 1, 1, 0, '{0,1,1,5,0,0,1});
		run(slms_pkg::TX_ACK, 1, slms_pkg::EV_BAD_DATA, 0, 1, 2, 0, 2, '{0,1,1,0,1,2,1});
		run(slms_pkg::TX_ACK, 5, slms_pkg::EV_BAD_DATA, 0, 1, 1, 0, 0, '{0,1,1,0,4,0,1});
		run(slms_pkg::TX_QENQ, 0, slms_pkg::EV_NAK, 1, 0, 1, 0, -1, '{1,0,0,0,0,0,0});
		run(slms_pkg::TX_QENQ, 4, slms_pkg::EV_BAD_DATA, 1, 0, 1, 0, -1, '{5,0,0,0,0,0,0});
		run(slms_pkg::TX_QENQ, 5, slms_pkg::EV_BAD_DATA, 1, 0, 1, 0, -1, '{5,0,0,0,0,0,0});
		run(slms_pkg::TX_QENQ, 1, slms_pkg::EV_ENQ, 1, 0, 1, 0, -1, '{2,0,0,0,0,0,0});
		run(slms_pkg::TX_HDR, 1, slms_pkg::EV_ENQ, 0, 0, 1, 0, 0, '{0,1,1,0,0,0,1});
		run(slms_pkg::TX_DATA, 1, slms_pkg::EV_ENQ, 0, 0, 1, 1, 0, '{0,1,1,1,0,0,1});
		run(slms_pkg::TX_ACK, 1, slms_pkg::EV_ENQ, 0, 1, 1, 0, 0, '{0,1,1,0,0,0,1});
		run(slms_pkg::TX_ACK, 1, slms_pkg::EV_STX, 0, 1, 1, 0, 0, '{0,1,1,0,0,0,1});
		for (int s = 0; s < 3; s++)
			for (int j = 0; j < 5; j++)
				run(ks[s], 1, evs[j], 0, 0, 1, s / 2, 0, '{0, 1, s > 0, s > 1, 0, 0, 1});
		results();
	end
endmodule : test_serial_link_master_sequencer

`default_nettype wire
